// File: hw/fpc_front_panel.v
// front panel controller: indicators, button classification, display mode and timers
`timescale 1ns/100ps
`include "fpc_defines.vh"

// Overview of operation
// - normal mode flashes the energy indicator once per imported Wh, 1,000 per kWh.
// - test mode flashes at 10,000 per unit for imported Wh or inductive varh.
// - test mode stops energy and demand accumulation.
// - receive and transmit indicators flash while the primary serial port is busy.
// - each phase voltage indicator lights while that voltage input is present.
// - presses are short, long (1 to 2 s) or extended (5 s or more).
// - page-advance button acts on press: page in data mode, item in programming.
// - confirm acts on release; short advances displays, over 5 s enters programming.
// - in programming a short confirm moves on, a one second hold selects.
// - both buttons briefly pressed and released in data mode return display to its start page.
// - with backlight off a short press only lights the backlight.
// - backlight stays on 1 to 10 minutes, default 1, or continuously.
// - auto-return after 1 to 30 idle minutes in data, 5 minutes in setup.
// - auto-return with auto-scroll enabled starts scrolling at once.
// - auto-scroll steps pages every 2 to 30 seconds.
// - without auto-return, scrolling resumes after 1 idle minute where it stopped.
// - a press stops scrolling when lit; when dark the second press does.
// - no auto-scroll while test mode is active.
// - display refreshes once per second, clock display twice per second.
// - seven data displays selected in turn by short confirm presses.
// - volts with one decimal at ratio 1.0, kilovolts with three above.
// - test mode shows test display instead of billing displays, mode reads test.
module fpc_front_panel #(
	parameter integer MS_CYCLES = `FPC_MS_NS / `FPC_CLK_NS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	input wire page_button_n,
	input wire confirm_button_n,
	input wire primary_serial_port_rx_busy,
	input wire primary_serial_port_tx_busy,
	input wire [2:0] voltage_present,
	input wire imp_wh_quantum,
	input wire imp_wh_test_quantum,
	input wire imp_varh_test_quantum,
	output reg energy_led_q,
	output reg accumulate_en_q,
	output reg rx_led_q,
	output reg tx_led_q,
	output reg phase_one_voltage_indicator_q,
	output reg phase_two_voltage_indicator_q,
	output reg phase_three_voltage_indicator_q,
	output reg page_step_q,
	output reg display_step_q,
	output reg param_enter_q,
	output reg menu_select_q,
	output reg start_page_q,
	output reg return_default_q,
	output reg prog_mode_q,
	output reg [2:0] display_idx_q,
	output reg [1:0] press_class_q,
	output reg backlight_q,
	output reg scrolling_q,
	output reg refresh_q,
	output reg volt_kv_q,
	output reg test_display_q
);
	localparam [31:0] MS_SPAN = MS_CYCLES - 1;
	localparam [16:0] MS_LAST = MS_SPAN[16:0];
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_HELD = 3'b010;
	localparam [2:0] S_BOTH = 3'b100;

	// clamp a programmed value into its legal range
	function [4:0] fpc_clamp;
		input [4:0] v;
		input [4:0] lo;
		input [4:0] hi;
		begin
			fpc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	// minutes to seconds; 30 minutes still fits 11 bits
	function [10:0] fpc_min2sec;
		input [4:0] m;
		begin
			fpc_min2sec = {6'h00, m} * 11'h03c;
		end
	endfunction

	// press class from hold time; 2 to 5 s is no class at all
	function [1:0] fpc_class;
		input [12:0] ms;
		begin
			if (ms < `FPC_LONG_MS)
				fpc_class = `FPC_CLS_SHORT;
			else if (ms <= `FPC_LONG_MAX_MS)
				fpc_class = `FPC_CLS_LONG;
			else if (ms >= `FPC_EXT_MS)
				fpc_class = `FPC_CLS_EXT;
			else
				fpc_class = `FPC_CLS_NONE;
		end
	endfunction

	reg [6:0] ctrl_q;
	reg [3:0] bl_min_q;
	reg [4:0] ar_min_q;
	reg [4:0] sc_sec_q;
	reg clear_q;
	reg [16:0] ms_cnt_q;
	reg ms_tick_q;
	reg [9:0] sec_ms_q;
	reg sec_tick_q;
	reg [9:0] ref_ms_q;
	reg [1:0] btn_s1_q;
	reg [1:0] btn_s2_q;
	reg [1:0] btn_db_q;
	reg [1:0] btn_prev_q;
	reg [4:0] db_cnt_q [0:1];
	reg [1:0] act_s1_q;
	reg [1:0] act_s2_q;
	reg [2:0] volt_s1_q;
	reg [2:0] volt_s2_q;
	reg [6:0] flash_ms_q;
	reg flash_q;
	reg [3:0] led_ms_q;
	reg [2:0] st_q;
	reg [12:0] hold_ms_q;
	reg swallow_q;
	reg [10:0] idle_sec_q;
	reg [10:0] bl_sec_q;
	reg [4:0] sc_cnt_q;
	integer i;

	wire test_w = ctrl_q[`FPC_CTRL_TEST];
	wire apb_acc = psel & penable & pready_q;
	wire [1:0] rise_w = btn_db_q & ~btn_prev_q;
	wire [10:0] ar_lim_w = prog_mode_q ? `FPC_SETUP_RET_SEC :
		fpc_min2sec(fpc_clamp(ar_min_q, `FPC_AR_MIN_LO, `FPC_AR_MIN_HI));
	wire [10:0] idle_lim_w = ctrl_q[`FPC_CTRL_AR_EN] ? ar_lim_w : `FPC_NOAR_SCROLL_SEC;
	wire [10:0] bl_lim_w = fpc_min2sec(
		fpc_clamp({1'b0, bl_min_q}, {1'b0, `FPC_BL_MIN_LO}, {1'b0, `FPC_BL_MIN_HI}));
	wire [4:0] sc_lim_w = fpc_clamp(sc_sec_q, `FPC_SC_SEC_LO, `FPC_SC_SEC_HI);
	wire [1:0] cls_w = fpc_class(hold_ms_q);
	wire scroll_ok_w = ctrl_q[`FPC_CTRL_AS_EN] & ~test_w;
	// in test mode the second billing display is skipped, the first shows test data
	wire [2:0] next_disp_w = (display_idx_q == `FPC_NUM_DISP - 3'h1) ? 3'h0 :
		((test_w && display_idx_q == 3'h0) ? 3'h2 : display_idx_q + 3'h1);

	// apb slave: one wait state so read data comes from a flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			ctrl_q <= `FPC_CTRL_RESET;
			bl_min_q <= `FPC_BL_MIN_RESET;
			ar_min_q <= `FPC_AR_MIN_RESET;
			sc_sec_q <= `FPC_SC_SEC_RESET;
			clear_q <= 1'b0;
		end
		else
		begin
			pready_q <= psel & penable & ~pready_q;
			clear_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			if (psel & penable & ~pready_q)
			begin
				case (paddr)
					`FPC_CTRL_ADDR: prdata_q <= {25'h0, ctrl_q};
					`FPC_TIME_ADDR: prdata_q <= {11'h0, sc_sec_q, 3'h0, ar_min_q, 4'h0, bl_min_q};
					`FPC_STAT_ADDR: prdata_q <= {21'h0, press_class_q, volt_s2_q,
						scrolling_q, backlight_q, display_idx_q, prog_mode_q};
					default: pslverr_q <= 1'b1;
				endcase
			end
			if (apb_acc & pwrite)
			begin
				if (paddr == `FPC_CTRL_ADDR)
				begin
					ctrl_q <= pwdata[6:0];
					clear_q <= pwdata[`FPC_CTRL_CLEAR];
				end
				if (paddr == `FPC_TIME_ADDR)
				begin
					bl_min_q <= pwdata[`FPC_TIME_BL_LSB +: 4];
					ar_min_q <= pwdata[`FPC_TIME_AR_LSB +: 5];
					sc_sec_q <= pwdata[`FPC_TIME_SC_LSB +: 5];
				end
			end
		end
	end

	// time base: millisecond and second ticks, refresh and flash rates
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt_q <= 17'h00000;
			ms_tick_q <= 1'b0;
			sec_ms_q <= 10'h000;
			sec_tick_q <= 1'b0;
			ref_ms_q <= 10'h000;
			refresh_q <= 1'b0;
			flash_ms_q <= 7'h00;
			flash_q <= 1'b0;
		end
		else
		begin
			ms_tick_q <= (ms_cnt_q == MS_LAST);
			ms_cnt_q <= (ms_cnt_q == MS_LAST) ? 17'h00000 : ms_cnt_q + 17'h00001;
			sec_tick_q <= 1'b0;
			refresh_q <= 1'b0;
			if (ms_tick_q)
			begin
				sec_ms_q <= (sec_ms_q == `FPC_SEC_MS - 10'h001) ? 10'h000 : sec_ms_q + 10'h001;
				sec_tick_q <= (sec_ms_q == `FPC_SEC_MS - 10'h001);
				// clock page needs twice the rate so the seconds digit never skips
				if (ref_ms_q >= (ctrl_q[`FPC_CTRL_CLK_PAGE] ? `FPC_HALF_SEC_MS : `FPC_SEC_MS) - 10'h001)
				begin
					ref_ms_q <= 10'h000;
					refresh_q <= 1'b1;
				end
				else
					ref_ms_q <= ref_ms_q + 10'h001;
				flash_ms_q <= (flash_ms_q == `FPC_FLASH_MS - 7'h01) ? 7'h00 : flash_ms_q + 7'h01;
				if (flash_ms_q == `FPC_FLASH_MS - 7'h01)
					flash_q <= ~flash_q;
			end
		end
	end

	// pin synchronisers, debounce and plain indicators
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			btn_s1_q <= 2'b00;
			btn_s2_q <= 2'b00;
			btn_db_q <= 2'b00;
			btn_prev_q <= 2'b00;
			act_s1_q <= 2'h0;
			act_s2_q <= 2'h0;
			volt_s1_q <= 3'h0;
			volt_s2_q <= 3'h0;
			for (i = 0; i < 2; i = i + 1)
				db_cnt_q[i] <= 5'h00;
			rx_led_q <= 1'b0;
			tx_led_q <= 1'b0;
			phase_one_voltage_indicator_q <= 1'b0;
			phase_two_voltage_indicator_q <= 1'b0;
			phase_three_voltage_indicator_q <= 1'b0;
			volt_kv_q <= 1'b0;
			accumulate_en_q <= 1'b1;
		end
		else
		begin
			btn_s1_q <= {~confirm_button_n, ~page_button_n};
			btn_s2_q <= btn_s1_q;
			btn_prev_q <= btn_db_q;
			// a level must hold for the debounce time before it is believed
			for (i = 0; i < 2; i = i + 1)
			begin
				if (clear_q || btn_s2_q[i] == btn_db_q[i])
					db_cnt_q[i] <= 5'h00;
				else if (ms_tick_q && db_cnt_q[i] == `FPC_DEBOUNCE_MS - 5'h01)
				begin
					btn_db_q[i] <= btn_s2_q[i];
					db_cnt_q[i] <= 5'h00;
				end
				else if (ms_tick_q)
					db_cnt_q[i] <= db_cnt_q[i] + 5'h01;
			end
			act_s1_q <= {primary_serial_port_tx_busy, primary_serial_port_rx_busy};
			act_s2_q <= act_s1_q;
			volt_s1_q <= voltage_present;
			volt_s2_q <= volt_s1_q;
			rx_led_q <= act_s2_q[0] & flash_q;
			tx_led_q <= act_s2_q[1] & flash_q;
			phase_one_voltage_indicator_q <= volt_s2_q[0];
			phase_two_voltage_indicator_q <= volt_s2_q[1];
			phase_three_voltage_indicator_q <= volt_s2_q[2];
			volt_kv_q <= ctrl_q[`FPC_CTRL_PT_GT1];
			accumulate_en_q <= ~test_w;
		end
	end

	// energy pulse indicator, stretched so the eye can see each quantum
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			energy_led_q <= 1'b0;
			led_ms_q <= 4'h0;
		end
		else if ((!test_w && imp_wh_quantum) ||
			(test_w && (ctrl_q[`FPC_CTRL_VARH] ? imp_varh_test_quantum : imp_wh_test_quantum)))
		begin
			energy_led_q <= 1'b1;
			led_ms_q <= 4'h0;
		end
		else if (ms_tick_q && energy_led_q)
		begin
			led_ms_q <= led_ms_q + 4'h1;
			if (led_ms_q == `FPC_LED_MS - 4'h1)
				energy_led_q <= 1'b0;
		end
	end

	// button state machine, display mode and idle timers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= S_IDLE;
			hold_ms_q <= 13'h0000;
			swallow_q <= 1'b0;
			page_step_q <= 1'b0;
			display_step_q <= 1'b0;
			param_enter_q <= 1'b0;
			menu_select_q <= 1'b0;
			start_page_q <= 1'b0;
			return_default_q <= 1'b0;
			prog_mode_q <= 1'b0;
			display_idx_q <= 3'h0;
			press_class_q <= `FPC_CLS_NONE;
			backlight_q <= 1'b1;
			scrolling_q <= 1'b0;
			idle_sec_q <= 11'h000;
			bl_sec_q <= 11'h000;
			sc_cnt_q <= 5'h00;
			test_display_q <= 1'b0;
		end
		else
		begin
			page_step_q <= 1'b0;
			display_step_q <= 1'b0;
			param_enter_q <= 1'b0;
			menu_select_q <= 1'b0;
			start_page_q <= 1'b0;
			return_default_q <= 1'b0;
			test_display_q <= test_w & ~prog_mode_q & (display_idx_q == 3'h0);
			if (ms_tick_q && st_q != S_IDLE && hold_ms_q != 13'h1fff)
				hold_ms_q <= hold_ms_q + 13'h0001;
			if (sec_tick_q && idle_sec_q != 11'h7ff)
				idle_sec_q <= idle_sec_q + 11'h001;
			if (sec_tick_q && backlight_q)
				bl_sec_q <= bl_sec_q + 11'h001;
			if (sec_tick_q && backlight_q && !ctrl_q[`FPC_CTRL_BL_CONT] && bl_sec_q >= bl_lim_w - 11'h001)
				backlight_q <= 1'b0;
			// idle timeout: auto-return, or resumed scrolling when it is off
			if (sec_tick_q && idle_sec_q == idle_lim_w - 11'h001)
			begin
				if (ctrl_q[`FPC_CTRL_AR_EN])
				begin
					return_default_q <= 1'b1;
					prog_mode_q <= 1'b0;
					display_idx_q <= 3'h0;
					scrolling_q <= scroll_ok_w;
				end
				else
					scrolling_q <= scroll_ok_w & ~prog_mode_q;
				sc_cnt_q <= 5'h00;
			end
			else if (sec_tick_q && scrolling_q)
			begin
				sc_cnt_q <= (sc_cnt_q >= sc_lim_w - 5'h01) ? 5'h00 : sc_cnt_q + 5'h01;
				page_step_q <= (sc_cnt_q >= sc_lim_w - 5'h01);
			end
			if (test_w)
				scrolling_q <= 1'b0;
			case (st_q)
				S_IDLE:
				begin
					if (rise_w != 2'b00)
					begin
						hold_ms_q <= 13'h0000;
						idle_sec_q <= 11'h000;
						bl_sec_q <= 11'h000;
						backlight_q <= 1'b1;
						// a dark press only lights up, so it cannot stop scrolling
						swallow_q <= ~backlight_q | scrolling_q;
						if (backlight_q)
							scrolling_q <= 1'b0;
						st_q <= (btn_db_q == 2'b11) ? S_BOTH : S_HELD;
						if (rise_w == 2'b01 && btn_db_q == 2'b01 && backlight_q && !scrolling_q)
							page_step_q <= 1'b1;
					end
				end
				S_HELD:
				begin
					if (btn_db_q == 2'b11)
						st_q <= S_BOTH;
					else if (btn_db_q == 2'b00)
					begin
						st_q <= S_IDLE;
						if (btn_prev_q[1])
						begin
							press_class_q <= cls_w;
							if (!swallow_q && !prog_mode_q)
							begin
								if (cls_w == `FPC_CLS_SHORT)
								begin
									display_step_q <= 1'b1;
									display_idx_q <= next_disp_w;
								end
								if (cls_w == `FPC_CLS_LONG)
									param_enter_q <= 1'b1;
								if (cls_w == `FPC_CLS_EXT)
								begin
									prog_mode_q <= 1'b1;
									scrolling_q <= 1'b0;
								end
							end
							else if (!swallow_q)
							begin
								if (hold_ms_q < `FPC_LONG_MS)
									page_step_q <= 1'b1;
								else
									menu_select_q <= 1'b1;
							end
						end
						else
							press_class_q <= cls_w;
					end
				end
				S_BOTH:
				begin
					if (btn_db_q == 2'b00)
					begin
						st_q <= S_IDLE;
						press_class_q <= cls_w;
						if (!swallow_q && !prog_mode_q && cls_w == `FPC_CLS_SHORT)
							start_page_q <= 1'b1;
					end
				end
				default: st_q <= S_IDLE;
			endcase
			if (clear_q)
			begin
				st_q <= S_IDLE;
				hold_ms_q <= 13'h0000;
			end
		end
	end
endmodule // fpc_front_panel

// File: hw/fpc_defines.vh
// constants for the front panel controller: register map, fields, reset values, timing
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
// register byte offsets
`define FPC_CTRL_ADDR 12'h000
`define FPC_TIME_ADDR 12'h004
`define FPC_STAT_ADDR 12'h008
// control register fields
`define FPC_CTRL_TEST 0
`define FPC_CTRL_VARH 1
`define FPC_CTRL_AR_EN 2
`define FPC_CTRL_AS_EN 3
`define FPC_CTRL_BL_CONT 4
`define FPC_CTRL_PT_GT1 5
`define FPC_CTRL_CLK_PAGE 6
`define FPC_CTRL_CLEAR 7
`define FPC_CTRL_RESET 7'h00
// timing register fields and reset values
`define FPC_TIME_BL_LSB 0
`define FPC_TIME_AR_LSB 8
`define FPC_TIME_SC_LSB 16
`define FPC_BL_MIN_RESET 4'h1
`define FPC_AR_MIN_RESET 5'h05
`define FPC_SC_SEC_RESET 5'h05
// programmable ranges
`define FPC_BL_MIN_LO 4'h1
`define FPC_BL_MIN_HI 4'ha
`define FPC_AR_MIN_LO 5'h01
`define FPC_AR_MIN_HI 5'h1e
`define FPC_SC_SEC_LO 5'h02
`define FPC_SC_SEC_HI 5'h1e
// clock and time base
`define FPC_CLK_NS 10
`define FPC_MS_NS 1000000
// button timing in ms
`define FPC_DEBOUNCE_MS 5'h14
`define FPC_LONG_MS 13'h03e8
`define FPC_LONG_MAX_MS 13'h07d0
`define FPC_EXT_MS 13'h1388
// other times
`define FPC_SEC_MS 10'h3e8
`define FPC_HALF_SEC_MS 10'h1f4
`define FPC_LED_MS 4'ha
`define FPC_FLASH_MS 7'h32
`define FPC_SETUP_RET_SEC 11'h12c
`define FPC_NOAR_SCROLL_SEC 11'h03c
// press classes
`define FPC_CLS_NONE 2'h0
`define FPC_CLS_SHORT 2'h1
`define FPC_CLS_LONG 2'h2
`define FPC_CLS_EXT 2'h3
// number of data displays
`define FPC_NUM_DISP 3'h7
`endif

// File: sim/fpc_front_panel_props.sv
// port-level checker for the front panel controller
`timescale 1ns/100ps
`include "fpc_defines.vh"
module fpc_front_panel_props #(
	parameter integer MS_CYCLES = 100000
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready_q,
	input wire primary_serial_port_rx_busy,
	input wire primary_serial_port_tx_busy,
	input wire [2:0] voltage_present,
	input wire imp_wh_quantum,
	input wire energy_led_q,
	input wire accumulate_en_q,
	input wire rx_led_q,
	input wire tx_led_q,
	input wire phase_one_voltage_indicator_q,
	input wire phase_two_voltage_indicator_q,
	input wire phase_three_voltage_indicator_q,
	input wire display_step_q,
	input wire menu_select_q,
	input wire start_page_q,
	input wire prog_mode_q,
	input wire [2:0] display_idx_q,
	input wire [1:0] press_class_q,
	input wire scrolling_q,
	input wire refresh_q
);
	localparam integer SEC = 1000 * MS_CYCLES;
	integer gap_q;
	logic seen_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// refresh spacing; the first pulse after reset only arms the check
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gap_q <= 1;
			seen_q <= 1'b0;
		end
		else
		begin
			gap_q <= refresh_q ? 1 : gap_q + 1;
			seen_q <= seen_q | refresh_q;
		end
	end
	apb_wait_a: assert property (psel && penable && !pready_q |=> pready_q)
		else $error("apb access not answered after one wait state");
	energy_pulse_a: assert property (imp_wh_quantum && accumulate_en_q |=> energy_led_q)
		else $error("energy indicator missed a normal quantum");
	volt_ind_a: assert property ({phase_three_voltage_indicator_q,
		phase_two_voltage_indicator_q, phase_one_voltage_indicator_q} == $past(voltage_present, 3))
		else $error("voltage indicators do not follow inputs");
	com_led_a: assert property ((!primary_serial_port_rx_busy && !primary_serial_port_tx_busy)[*4]
		|=> !rx_led_q && !tx_led_q) else $error("port indicator lit while idle");
	short_step_a: assert property (display_step_q |-> !prog_mode_q
		&& press_class_q == `FPC_CLS_SHORT) else $error("display step without short press");
	disp_wrap_a: assert property (display_step_q && accumulate_en_q |-> display_idx_q ==
		($past(display_idx_q) == 3'h6 ? 3'h0 : $past(display_idx_q) + 3'h1))
		else $error("display index did not step in turn");
	select_prog_a: assert property (menu_select_q |-> prog_mode_q)
		else $error("menu select outside programming");
	start_page_a: assert property (start_page_q |-> !prog_mode_q)
		else $error("start page outside data mode");
	refresh_gap_a: assert property (refresh_q && seen_q |-> gap_q == SEC || gap_q == SEC / 2)
		else $error("refresh spacing wrong");
	no_scroll_a: assert property (!accumulate_en_q && $past(!accumulate_en_q) |-> !scrolling_q)
		else $error("scrolling in test mode");
endmodule // fpc_front_panel_props
bind fpc_front_panel fpc_front_panel_props #(.MS_CYCLES(MS_CYCLES)) u_props (.*);

// File: sim/fpc_operator.sv
// operator model: two push buttons with pull-ups
`timescale 1ns/100ps
module fpc_operator (
	input wire logic pclk,
	output logic page_button_n,
	output logic confirm_button_n
);
	// released buttons read high through their pull-ups
	initial
	begin
		page_button_n = 1'b1;
		confirm_button_n = 1'b1;
	end
	// press the buttons in mask, bit0 page and bit1 confirm
	task push(input logic [1:0] mask);
		@(posedge pclk);
		page_button_n <= ~mask[0];
		confirm_button_n <= ~mask[1];
	endtask
	// let both go
	task lift;
		@(posedge pclk);
		page_button_n <= 1'b1;
		confirm_button_n <= 1'b1;
	endtask
endmodule // fpc_operator

// File: sim/fpc_front_panel_test.sv
// self-checking bench for the front panel controller
`timescale 1ns/100ps
`include "fpc_defines.vh"
module fpc_front_panel_test;
	localparam integer MS = 1; // one cycle per ms keeps the idle-minute timers inside the run
	localparam integer LIMIT = 100000;
	logic pclk, presetn, psel, penable, pwrite, clr;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic primary_serial_port_rx_busy, primary_serial_port_tx_busy;
	logic [2:0] voltage_present;
	logic imp_wh_quantum, imp_wh_test_quantum, imp_varh_test_quantum;
	logic [5:0] evt;
	wire page_button_n, confirm_button_n, pready_q, pslverr_q, energy_led_q;
	wire [31:0] prdata_q;
	wire accumulate_en_q, rx_led_q, tx_led_q, phase_one_voltage_indicator_q;
	wire phase_two_voltage_indicator_q, phase_three_voltage_indicator_q;
	wire page_step_q, display_step_q, param_enter_q, menu_select_q, start_page_q;
	wire return_default_q, prog_mode_q, backlight_q, scrolling_q, refresh_q;
	wire volt_kv_q, test_display_q;
	wire [2:0] display_idx_q;
	wire [1:0] press_class_q;
	integer num_errors, compares, cycles, gap, last_gap;
	fpc_front_panel #(.MS_CYCLES(MS)) DUT (.*);
	fpc_operator op (.*);
	always #5 pclk = ~pclk;
	// pulse catcher, refresh spacing and hang guard
	always @(posedge pclk)
	begin
		evt <= clr ? 6'h00 : evt | {return_default_q, param_enter_q, start_page_q, menu_select_q,
			display_step_q, page_step_q};
		gap <= refresh_q ? 1 : gap + 1;
		if (refresh_q)
			last_gap <= gap;
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			num_errors = num_errors + 1;
			stop_test;
		end
	end
	function integer ms(input integer n);
		ms = n * MS;
	endfunction
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one apb transfer; the request holds until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic err);
		integer n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n = n + 1;
		end
		while (pready_q !== 1'h1 && n < 20);
		check({pready_q, pslverr_q}, {1'h1, err});
		if (!w)
			check(prdata_q, exp);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task clear;
		@(posedge pclk);
		clr <= 1'h1;
		@(posedge pclk);
		clr <= 1'h0;
	endtask
	// bounded wait for a caught pulse
	task wait_evt(input integer i);
		integer n;
		n = 0;
		while (evt[i] !== 1'h1 && n < ms(60))
		begin
			@(posedge pclk);
			n = n + 1;
		end
		check(evt[i], 1'h1);
	endtask
	task press(input logic [1:0] mask, input integer hold);
		clear;
		op.push(mask);
		repeat (ms(hold)) @(posedge pclk);
		op.lift;
	endtask
	// one quantum pulse; afterwards wait out the 10 ms indicator hold
	task eled(input logic [2:0] q, input logic exp);
		@(posedge pclk);
		{imp_varh_test_quantum, imp_wh_test_quantum, imp_wh_quantum} <= q;
		@(posedge pclk);
		{imp_varh_test_quantum, imp_wh_test_quantum, imp_wh_quantum} <= 3'h0;
		@(posedge pclk);
		check(energy_led_q, exp);
		repeat (ms(12)) @(posedge pclk);
	endtask
	task t_regs;
		apb(1'h0, `FPC_TIME_ADDR, 32'h0, 32'h00050501, 1'h0);
		apb(1'h0, `FPC_STAT_ADDR, 32'h0, 32'h00000010, 1'h0);
		apb(1'h0, 12'h00c, 32'h0, 32'h0, 1'h1);
		apb(1'h1, 12'h00c, 32'hffffffff, 32'h0, 1'h1);
		apb(1'h1, `FPC_TIME_ADDR, 32'h001e1e0a, 32'h0, 1'h0);
		apb(1'h0, `FPC_TIME_ADDR, 32'h0, 32'h001e1e0a, 1'h0);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h000000a0, 32'h0, 1'h0);
		apb(1'h0, `FPC_CTRL_ADDR, 32'h0, 32'h00000020, 1'h0);
		check(volt_kv_q, 1'h1);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h0, 32'h0, 1'h0);
		repeat (2) @(posedge pclk);
		check(volt_kv_q, 1'h0);
	endtask
	task t_energy;
		eled(3'h1, 1'h1);
		eled(3'h2, 1'h0);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h1, 32'h0, 1'h0);
		repeat (2) @(posedge pclk);
		check({accumulate_en_q, test_display_q}, 2'h1);
		eled(3'h1, 1'h0);
		eled(3'h2, 1'h1);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h3, 32'h0, 1'h0);
		eled(3'h2, 1'h0);
		eled(3'h4, 1'h1);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h0, 32'h0, 1'h0);
		repeat (2) @(posedge pclk);
		check({accumulate_en_q, test_display_q}, 2'h2);
	endtask
	// rx flashes while busy with tx dark, then tx flashes while busy; phase inputs mirrored
	task t_leds;
		integer hi;
		logic tx_any;
		hi = 0;
		tx_any = 1'h0;
		@(posedge pclk);
		voltage_present <= 3'h5;
		primary_serial_port_rx_busy <= 1'h1;
		repeat (ms(120))
		begin
			@(posedge pclk);
			hi = hi + rx_led_q;
			tx_any = tx_any | tx_led_q;
		end
		primary_serial_port_rx_busy <= 1'h0;
		check(hi > 0 && hi < ms(120), 1'h1);
		check(tx_any, 1'h0);
		hi = 0;
		primary_serial_port_tx_busy <= 1'h1;
		repeat (ms(120))
		begin
			@(posedge pclk);
			hi = hi + tx_led_q;
		end
		primary_serial_port_tx_busy <= 1'h0;
		check(hi > 0 && hi < ms(120), 1'h1);
		check({phase_three_voltage_indicator_q, phase_two_voltage_indicator_q,
			phase_one_voltage_indicator_q}, 3'h5);
		apb(1'h0, `FPC_STAT_ADDR, 32'h0, 32'h00000150, 1'h0);
	endtask
	task t_disp;
		integer i;
		for (i = 0; i < 7; i = i + 1)
		begin
			press(2'h2, 40);
			wait_evt(1);
			check(display_idx_q, (i + 1) % 7);
			check({evt[0], press_class_q}, {1'h0, `FPC_CLS_SHORT});
		end
		press(2'h2, 1200);
		wait_evt(4);
		check({evt[1], press_class_q}, {1'h0, `FPC_CLS_LONG});
	endtask
	// the page step must come while the button is still held
	task t_page;
		clear;
		op.push(2'h1);
		wait_evt(0);
		op.lift;
		repeat (ms(40)) @(posedge pclk);
		check({evt[1], display_idx_q}, 4'h0);
	endtask
	task t_both;
		press(2'h3, 40);
		wait_evt(3);
		check(evt[1], 1'h0);
	endtask
	// auto-return after one idle minute, then a scroll step every 2 s until a press
	task t_auto;
		integer n;
		apb(1'h1, `FPC_TIME_ADDR, 32'h0002010a, 32'h0, 1'h0);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h0000000c, 32'h0, 1'h0);
		press(2'h2, 40);
		n = 0;
		while (evt[5] !== 1'h1 && n < ms(61000))
		begin
			@(posedge pclk);
			n = n + 1;
		end
		check({evt[5], display_idx_q}, 4'h8);
		check(scrolling_q, 1'h1);
		clear;
		repeat (ms(1500)) @(posedge pclk);
		check(evt[0], 1'h0);
		repeat (ms(600)) @(posedge pclk);
		check(evt[0], 1'h1);
		press(2'h1, 40);
		repeat (ms(40)) @(posedge pclk);
		check({evt[0], scrolling_q}, 2'h0);
		apb(1'h1, `FPC_CTRL_ADDR, 32'h0, 32'h0, 1'h0);
	endtask
	task t_prog;
		press(2'h2, 5200);
		repeat (ms(40)) @(posedge pclk);
		check({prog_mode_q, press_class_q}, {1'h1, `FPC_CLS_EXT});
		press(2'h2, 40);
		wait_evt(0);
		check(evt[1], 1'h0);
		press(2'h2, 1200);
		wait_evt(2);
		check(press_class_q, `FPC_CLS_LONG);
		apb(1'h0, `FPC_STAT_ADDR, 32'h0, 32'h00000551, 1'h0);
	endtask
	initial
	begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		primary_serial_port_rx_busy = 1'h0;
		primary_serial_port_tx_busy = 1'h0;
		voltage_present = 3'h0;
		{imp_varh_test_quantum, imp_wh_test_quantum, imp_wh_quantum} = 3'h0;
		clr = 1'h1;
		num_errors = 0;
		compares = 0;
		cycles = 0;
		gap = 0;
		last_gap = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		clr <= 1'h0;
		t_regs;
		t_energy;
		t_leds;
		t_disp;
		t_page;
		t_both;
		t_auto;
		t_prog;
		check(last_gap, ms(1000));
		stop_test;
	end
endmodule // fpc_front_panel_test
